// ---- drhc_defines.vh ----
`ifndef DRHC_DEFINES_VH
`define DRHC_DEFINES_VH
// ==========================================
// Loop states
`define DRHC_ST_FREE 2'h0
`define DRHC_ST_ACQ 2'h1
`define DRHC_ST_LOCK 2'h2
`define DRHC_ST_HOLD 2'h3
// ==========================================
// Monitor detectors per input, bit order in each group
`define DRHC_NDET 5
`define DRHC_DET_FREQ 0
`define DRHC_DET_MISS 1
`define DRHC_DET_EARLY 2
`define DRHC_DET_RUNT 3
`define DRHC_DET_PPS 4
// ==========================================
// Timing
`define DRHC_CLK_NS 10
`define DRHC_LOCK_TIME_NS 10000
`define DRHC_LOCK_CYC ((`DRHC_LOCK_TIME_NS + `DRHC_CLK_NS - 1) / `DRHC_CLK_NS)
// ==========================================
// Misc values
`define DRHC_POSTDIV_BYPASS 4'h1
`define DRHC_HIST_SHIFT 8
`endif

// ---- drhc_dpll_ref_ctrl.v ----
`timescale 1ns/1ps
`include "drhc_defines.vh"
module drhc_dpll_ref_ctrl #(
   parameter NREF = 2,
   parameter CW = 2,
   parameter PW = 3,
   parameter TW = 16,
   parameter TSW = 24,
   parameter LOCK_CYC = `DRHC_LOCK_CYC
) (
   input wire core_clk, // System clock
   input wire rstn, // Async reset, active low
   input wire dpllEn, // DPLL enabled
   input wire [NREF-1:0] refPulse, // Reference edge pulses
   input wire cascPulse, // Cascade divider edge pulse
   input wire cascValid, // Cascade source usable
   input wire fbPulse, // Feedback divider edge pulse
   input wire [NREF-1:0] refFreqBad, // Frequency detector violation
   input wire [NREF-1:0] refRuntBad, // Runt detector violation
   input wire [NREF-1:0] refPpsBad, // PPS detector violation
   input wire [NREF*`DRHC_NDET-1:0] monEn, // Detector enables per input
   input wire [NREF*TW-1:0] missThr, // Missing pulse limit per input
   input wire [NREF*TW-1:0] earlyThr, // Early pulse limit per input
   input wire [(NREF+1)*PW-1:0] refPrio, // Priority per candidate, low wins
   input wire swManEn, // Software manual select
   input wire [CW-1:0] swManSel, // Software selected candidate
   input wire pinManEn, // Pin manual select
   input wire [CW-1:0] pinManSel, // Pin selected candidate
   input wire [39:0] nomNum, // Nominal numerator
   input wire [3:0] kpShift, // Proportional gain shift
   input wire [3:0] kiShift, // Integral gain shift
   input wire [TSW-1:0] lockThr, // Lock phase error limit
   input wire dcoEn, // DCO mode enable
   input wire dcoInc, // DCO increment pulse
   input wire dcoDec, // DCO decrement pulse
   input wire [39:0] frequencyDeviationStep, // DCO step
   input wire useDen24, // Use 24-bit denominator without DPLL
   input wire [23:0] den24, // Programmable denominator
   input wire apllRefSel, // 0 oscillator, 1 cascade
   input wire [3:0] postDiv3, // Third VCO post-divider
   input wire [NREF-1:0] clrLor, // Clear sticky loss flags
   input wire clrLockLost, // Clear sticky lock-lost flag
   output reg [CW-1:0] selQ, // Active candidate
   output reg [1:0] stateQ, // Loop state
   output reg [39:0] numQ, // APLL numerator
   output reg sdmCarryQ, // Divide by N+1 this cycle
   output reg den24SelQ, // 24-bit denominator in use
   output reg [23:0] den24Q, // Denominator value
   output reg apllRefSelQ, // APLL reference mux
   output reg apllFreeRunQ, // APLL free-running
   output reg bypassQ, // Post-divider bypass
   output reg [NREF-1:0] lossOfReferenceQ, // Live loss status
   output reg lockedQ, // Locked status
   output reg holdoverQ, // Holdover status
   output reg [NREF-1:0] stLorQ, // Sticky loss flags
   output reg stLockLostQ // Sticky lock-lost flag
);
   localparam NC = NREF + 1;

   // ==========================================
   // Helpers
   function [TSW-1:0] mag;
      input [TSW-1:0] e;
      begin
         mag = e[TSW-1] ? (~e + 1'b1) : e;
      end
   endfunction

   function [CW:0] pickBest;
      input [NC-1:0] v;
      input [NC*PW-1:0] p;
      integer i;
      reg [PW-1:0] bp;
      begin
         pickBest = {(CW+1){1'b0}};
         bp = {PW{1'b1}};
         for (i = 0; i < NC; i = i + 1) begin
            if (v[i] && (!pickBest[CW] || p[i*PW +: PW] < bp)) begin
               pickBest = {1'b1, i[CW-1:0]};
               bp = p[i*PW +: PW];
            end
         end
      end
   endfunction

   // ==========================================
   // Reference monitors
   wire [NREF*`DRHC_NDET-1:0] viol;
   wire [NREF-1:0] lorNow;
   genvar g;
   generate
      for (g = 0; g < NREF; g = g + 1) begin : gMon
         reg [TW-1:0] cntQ;
         reg earlyQ;
         wire [TW-1:0] missT = missThr[g*TW +: TW];
         wire [TW-1:0] earlyT = earlyThr[g*TW +: TW];
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               cntQ <= {TW{1'b0}};
               earlyQ <= 1'b0;
            end else if (refPulse[g]) begin
               earlyQ <= (cntQ < earlyT);
               cntQ <= {TW{1'b0}};
            end else if (cntQ != {TW{1'b1}}) begin
               cntQ <= cntQ + 1'b1;
            end
         end
         assign viol[g*`DRHC_NDET + `DRHC_DET_FREQ] = refFreqBad[g];
         assign viol[g*`DRHC_NDET + `DRHC_DET_MISS] = (cntQ > missT);
         assign viol[g*`DRHC_NDET + `DRHC_DET_EARLY] = earlyQ;
         assign viol[g*`DRHC_NDET + `DRHC_DET_RUNT] = refRuntBad[g];
         assign viol[g*`DRHC_NDET + `DRHC_DET_PPS] = refPpsBad[g];
         assign lorNow[g] = |(viol[g*`DRHC_NDET +: `DRHC_NDET] & monEn[g*`DRHC_NDET +: `DRHC_NDET]);
      end
   endgenerate

   // ==========================================
   // Reference choice
   wire [NC-1:0] candValid = {cascValid, ~lorNow};
   wire [NC-1:0] candPulse = {cascPulse, refPulse};
   wire [CW:0] best = pickBest(candValid, refPrio);
   reg [CW-1:0] tgtIdx;
   reg tgtOk;
   always @* begin
      if (pinManEn) begin
         tgtIdx = pinManSel;
      end else if (swManEn) begin
         tgtIdx = swManSel;
      end else begin
         tgtIdx = best[CW-1:0];
      end
      tgtOk = (pinManEn || swManEn) ? (tgtIdx < NC && candValid[tgtIdx]) : best[CW];
   end

   // ==========================================
   // Phase detector
   reg [TSW-1:0] tsQ;
   reg [TSW-1:0] fbTsQ;
   wire selPulse = candPulse[selQ];
   wire [TSW-1:0] err = tsQ - fbTsQ;
   wire errGood = (mag(err) <= lockThr);
   wire track = (stateQ == `DRHC_ST_ACQ) || (stateQ == `DRHC_ST_LOCK);
   wire upd = track && selPulse;

   // ==========================================
   // Loop state
   reg [1:0] stateD;
   reg [CW-1:0] selD;
   reg [15:0] lockCntQ;
   always @* begin
      stateD = stateQ;
      selD = selQ;
      case (stateQ)
         `DRHC_ST_FREE: begin
            if (dpllEn && tgtOk) begin
               stateD = `DRHC_ST_ACQ;
               selD = tgtIdx;
            end
         end
         `DRHC_ST_ACQ, `DRHC_ST_LOCK: begin
            if (!dpllEn) begin
               stateD = `DRHC_ST_FREE;
            end else if (!tgtOk) begin
               stateD = `DRHC_ST_HOLD;
            end else if (tgtIdx != selQ) begin
               selD = tgtIdx;
            end else if (stateQ == `DRHC_ST_ACQ && lockCntQ >= LOCK_CYC) begin
               stateD = `DRHC_ST_LOCK;
            end else if (stateQ == `DRHC_ST_LOCK && upd && !errGood) begin
               stateD = `DRHC_ST_ACQ;
            end
         end
         `DRHC_ST_HOLD: begin
            if (!dpllEn) begin
               stateD = `DRHC_ST_FREE;
            end else if (tgtOk) begin
               stateD = `DRHC_ST_ACQ;
               selD = tgtIdx;
            end
         end
         default: begin
            stateD = `DRHC_ST_FREE;
         end
      endcase
   end

   // ==========================================
   // Loop filter, history, DCO
   reg signed [39:0] integQ;
   reg signed [39:0] histQ;
   reg signed [39:0] dcoOffQ;
   wire signed [39:0] errX = {{(40-TSW){err[TSW-1]}}, err};
   wire signed [39:0] loopOut = integQ + (errX >>> kpShift);
   wire signed [39:0] histStep = ($signed(numQ) - histQ) >>> `DRHC_HIST_SHIFT;
   reg [39:0] sdmAccQ;
   wire [40:0] sdmSum = {1'b0, sdmAccQ} + {1'b0, numQ};

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tsQ <= {TSW{1'b0}};
         fbTsQ <= {TSW{1'b0}};
         stateQ <= `DRHC_ST_FREE;
         selQ <= {CW{1'b0}};
         lockCntQ <= 16'h0000;
         integQ <= 40'h0000000000;
         histQ <= 40'h0000000000;
         dcoOffQ <= 40'h0000000000;
         numQ <= 40'h0000000000;
         sdmAccQ <= 40'h0000000000;
         sdmCarryQ <= 1'b0;
      end else begin
         tsQ <= tsQ + 1'b1;
         if (fbPulse) begin
            fbTsQ <= tsQ;
         end
         stateQ <= stateD;
         selQ <= selD;
         // Settle counter restarts on a bad error at a selected-reference edge, on a reference change, or when leaving ACQ
         if (stateD != `DRHC_ST_ACQ || selD != selQ || (upd && !errGood)) begin
            lockCntQ <= 16'h0000;
         end else if (lockCntQ != 16'hffff) begin
            lockCntQ <= lockCntQ + 1'b1;
         end
         if (stateQ == `DRHC_ST_FREE && stateD == `DRHC_ST_ACQ) begin
            integQ <= 40'h0000000000;
         end else if (stateQ == `DRHC_ST_HOLD && stateD == `DRHC_ST_ACQ) begin
            integQ <= histQ - $signed(nomNum) - dcoOffQ;
         end else if (upd) begin
            integQ <= integQ + (errX >>> kiShift);
         end
         if (stateQ == `DRHC_ST_ACQ && stateD == `DRHC_ST_LOCK) begin
            histQ <= $signed(numQ);
         end else if (stateQ == `DRHC_ST_LOCK && upd) begin
            histQ <= histQ + histStep;
         end
         if (!dcoEn) begin
            dcoOffQ <= 40'h0000000000;
         end else if (dcoInc && !dcoDec) begin
            dcoOffQ <= dcoOffQ + $signed(frequencyDeviationStep);
         end else if (dcoDec && !dcoInc) begin
            dcoOffQ <= dcoOffQ - $signed(frequencyDeviationStep);
         end
         if (stateQ == `DRHC_ST_HOLD) begin
            numQ <= histQ;
         end else if (track) begin
            numQ <= $signed(nomNum) + loopOut + dcoOffQ;
         end else begin
            numQ <= $signed(nomNum) + dcoOffQ;
         end
         if (fbPulse) begin
            sdmAccQ <= sdmSum[39:0];
            sdmCarryQ <= sdmSum[40];
         end
      end
   end

   // ==========================================
   // APLL configuration and status
   wire lockLostEv = (stateQ == `DRHC_ST_LOCK) && (stateD != `DRHC_ST_LOCK);
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         den24SelQ <= 1'b0;
         den24Q <= 24'h000000;
         apllRefSelQ <= 1'b0;
         apllFreeRunQ <= 1'b1;
         bypassQ <= 1'b0;
         lossOfReferenceQ <= {NREF{1'b0}};
         lockedQ <= 1'b0;
         holdoverQ <= 1'b0;
         stLorQ <= {NREF{1'b0}};
         stLockLostQ <= 1'b0;
      end else begin
         den24SelQ <= !dpllEn && useDen24;
         den24Q <= den24;
         apllRefSelQ <= apllRefSel;
         apllFreeRunQ <= (stateD == `DRHC_ST_FREE);
         bypassQ <= (postDiv3 == `DRHC_POSTDIV_BYPASS);
         lossOfReferenceQ <= lorNow;
         lockedQ <= (stateD == `DRHC_ST_LOCK);
         holdoverQ <= (stateD == `DRHC_ST_HOLD);
         // Set wins over clear
         stLorQ <= (stLorQ & ~clrLor) | (lorNow & ~lossOfReferenceQ);
         stLockLostQ <= (stLockLostQ & ~clrLockLost) | lockLostEv;
      end
   end
endmodule // drhc_dpll_ref_ctrl

// ---- drhc_ref_src.sv ----
`timescale 1ns/1ps
// ====
// Reference, cascade and feedback edge source
module drhc_ref_src #(parameter PER = 10) (
   input wire core_clk, // Clock
   input wire rstn, // Reset, active low
   input wire [1:0] refOn, // Reference running
   input wire refFast, // Extra edge on reference 1
   output reg [1:0] refPulse, // Reference edges
   output reg cascPulse, // Cascade edges
   output reg fbPulse // Feedback edges
);
   reg [7:0] cntQ;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cntQ <= 8'h0;
         refPulse <= 2'h0;
         cascPulse <= 1'b0;
         fbPulse <= 1'b0;
      end else begin
         cntQ <= (cntQ == PER - 1) ? 8'h0 : cntQ + 8'h1;
         refPulse <= refOn & {cntQ == 0 || (refFast && cntQ == 3), cntQ == 0};
         cascPulse <= cntQ == 3;
         fbPulse <= cntQ == PER / 2;
      end
   end
endmodule // drhc_ref_src

// ---- drhc_dpll_ref_ctrl_properties.sv ----
`timescale 1ns/1ps
`include "drhc_defines.vh"
module drhc_props #(parameter NREF = 2) (
   input wire core_clk, // Clock
   input wire rstn, // Reset
   input wire dpllEn, // DPLL on
   input wire fbPulse, // Feedback edge
   input wire sdmCarryQ, // Modulator carry
   input wire [3:0] postDiv3, // Post-divider
   input wire [NREF-1:0] refFreqBad, // Frequency flag
   input wire [NREF*`DRHC_NDET-1:0] monEn, // Enables
   input wire [1:0] stateQ, // State
   input wire lockedQ, // Locked
   input wire holdoverQ, // Holdover
   input wire apllFreeRunQ, // Free run
   input wire bypassQ, // Bypass
   input wire den24SelQ, // Denominator
   input wire [NREF-1:0] lossOfReferenceQ, // Live loss
   input wire [NREF-1:0] stLorQ, // Sticky loss
   input wire stLockLostQ // Sticky lock-lost
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   bypass_on_one_a: assert property ((postDiv3 == 4'h1) |=> bypassQ) else $error("bypass missing");
   fixed_den_a: assert property (dpllEn |=> !den24SelQ) else $error("short denominator under loop");
   freq_loss_a: assert property ((monEn[`DRHC_DET_FREQ] && refFreqBad[0]) |=> lossOfReferenceQ[0])
      else $error("frequency loss missed");
   loss_sticky_a: assert property ($rose(lossOfReferenceQ[0]) |-> stLorQ[0]) else $error("sticky loss");
   hold_status_a: assert property (holdoverQ == (stateQ == `DRHC_ST_HOLD)) else $error("holdover status");
   lock_status_a: assert property (lockedQ == (stateQ == `DRHC_ST_LOCK)) else $error("lock status");
   free_run_a: assert property (!dpllEn |=> stateQ == `DRHC_ST_FREE && apllFreeRunQ) else $error("free run");
   lock_lost_a: assert property ((stateQ == `DRHC_ST_LOCK) ##1 (stateQ != `DRHC_ST_LOCK) |-> ##[0:1] stLockLostQ)
      else $error("lock lost flag");
   hold_entry_a: assert property ($rose(holdoverQ) |-> $past(stateQ) != `DRHC_ST_FREE)
      else $error("holdover from free");
   carry_hold_a: assert property (!fbPulse |=> $stable(sdmCarryQ)) else $error("carry moved");
endmodule // drhc_props
bind drhc_dpll_ref_ctrl drhc_props #(.NREF(NREF)) i_props (.core_clk(core_clk), .rstn(rstn), .dpllEn(dpllEn),
   .fbPulse(fbPulse), .sdmCarryQ(sdmCarryQ),
   .postDiv3(postDiv3), .refFreqBad(refFreqBad), .monEn(monEn), .stateQ(stateQ), .lockedQ(lockedQ),
   .holdoverQ(holdoverQ), .apllFreeRunQ(apllFreeRunQ), .bypassQ(bypassQ), .den24SelQ(den24SelQ),
   .lossOfReferenceQ(lossOfReferenceQ), .stLorQ(stLorQ), .stLockLostQ(stLockLostQ));

// ---- drhc_dpll_ref_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "drhc_defines.vh"
module drhc_dpll_ref_ctrl_tb;
   reg core_clk = 0, rstn = 0, dpllEn = 0, cascValid = 0, swManEn = 0, pinManEn = 0, refFast = 0;
   reg dcoEn = 0, dcoInc = 0, dcoDec = 0, useDen24 = 0, apllRefSel = 0, clrLockLost = 0;
   reg [1:0] refOn = 2'h3, refFreqBad = 0, refRuntBad = 0, refPpsBad = 0, swManSel = 0, pinManSel = 0, clrLor = 0;
   reg [9:0] monEn = 10'h3ff;
   reg [8:0] refPrio = 9'h1c8;
   reg [3:0] postDiv3 = 4'h4;
   reg [23:0] den24 = 24'h00abcd;
   reg [39:0] nomNum = 40'h4000000000, step = 40'h10, h;
   wire [1:0] refPulse, selQ, stateQ, loss_of_reference, stLorQ;
   wire cascPulse, fbPulse, sdmCarryQ, den24SelQ, apllRefSelQ, apllFreeRunQ, bypassQ, lockedQ, holdoverQ, stLockLostQ;
   wire [23:0] den24Q;
   wire [39:0] numQ;
   integer errors = 0, total_checks = 0, k;
   drhc_ref_src #(.PER(10)) i_src (.core_clk(core_clk), .rstn(rstn), .refOn(refOn), .refFast(refFast),
      .refPulse(refPulse), .cascPulse(cascPulse), .fbPulse(fbPulse));
   drhc_dpll_ref_ctrl #(.LOCK_CYC(20)) i_dut (.core_clk(core_clk), .rstn(rstn), .dpllEn(dpllEn),
      .refPulse(refPulse), .cascPulse(cascPulse), .cascValid(cascValid), .fbPulse(fbPulse),
      .refFreqBad(refFreqBad), .refRuntBad(refRuntBad), .refPpsBad(refPpsBad), .monEn(monEn),
      .missThr({16'd15, 16'd15}), .earlyThr({16'd8, 16'd5}), .refPrio(refPrio), .swManEn(swManEn),
      .swManSel(swManSel), .pinManEn(pinManEn), .pinManSel(pinManSel), .nomNum(nomNum),
      .kpShift(4'hf), .kiShift(4'hf), .lockThr(24'hffffff), .dcoEn(dcoEn), .dcoInc(dcoInc),
      .dcoDec(dcoDec), .frequencyDeviationStep(step), .useDen24(useDen24), .den24(den24),
      .apllRefSel(apllRefSel), .postDiv3(postDiv3), .clrLor(clrLor), .clrLockLost(clrLockLost),
      .selQ(selQ), .stateQ(stateQ), .numQ(numQ), .sdmCarryQ(sdmCarryQ), .den24SelQ(den24SelQ),
      .den24Q(den24Q), .apllRefSelQ(apllRefSelQ), .apllFreeRunQ(apllFreeRunQ), .bypassQ(bypassQ),
      .lossOfReferenceQ(loss_of_reference), .lockedQ(lockedQ), .holdoverQ(holdoverQ), .stLorQ(stLorQ), .stLockLostQ(stLockLostQ));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // ====
   // Shared tasks
   task complete_run;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [39:0] got, input [39:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task wait_state(input [1:0] s);
      integer i;
      begin
         i = 0;
         while (stateQ !== s && i < 500) begin
            cyc(1);
            i = i + 1;
         end
         if (i == 500) begin
            errors = errors + 1;
            complete_run;
         end
      end
   endtask
   // ====
   // Scenarios
   task t_free_dco;
      begin
         @(posedge core_clk) {useDen24, postDiv3, apllRefSel, dcoEn, dcoInc} <= {1'b1, 4'h1, 3'h7};
         @(posedge core_clk) dcoInc <= 0;
         cyc(2);
         chk(numQ, nomNum + step);
         chk(den24SelQ, 1);
         chk(den24Q, den24);
         chk(bypassQ, 1);
         chk(apllRefSelQ, 1);
         chk(apllFreeRunQ, 1);
         @(posedge core_clk) {dcoInc, dcoDec} <= 2'h3;
         @(posedge core_clk) dcoInc <= 0;
         @(posedge core_clk) dcoDec <= 0;
         cyc(2);
         chk(numQ, nomNum);
         @(posedge core_clk) {useDen24, postDiv3, apllRefSel} <= {1'b0, 4'h2, 1'b0};
      end
   endtask
   task t_acquire;
      begin
         @(posedge core_clk) dpllEn <= 1;
         wait_state(`DRHC_ST_LOCK);
         chk(selQ, 0);
         chk({lockedQ, apllFreeRunQ, bypassQ}, 3'h4);
      end
   endtask
   task t_monitors;
      begin
         for (k = 0; k < 3; k = k + 1) begin
            @(posedge core_clk) {refPpsBad[0], refRuntBad[0], refFreqBad[0]} <= 3'h1 << k;
            cyc(3);
            chk({loss_of_reference, stLorQ[0], selQ, holdoverQ}, {2'h1, 1'b1, 2'h1, 1'b0});
            @(posedge core_clk) {refPpsBad[0], refRuntBad[0], refFreqBad[0], clrLor} <= 5'h3;
            @(posedge core_clk) clrLor <= 0;
            cyc(3);
            chk({stLorQ, selQ}, 4'h0);
         end
         @(posedge core_clk) {monEn[`DRHC_DET_FREQ], refFreqBad[0]} <= 2'h1;
         cyc(3);
         chk({loss_of_reference[0], selQ}, 3'h0);
         @(posedge core_clk) {monEn[`DRHC_DET_FREQ], refFreqBad[0], refFast} <= 3'h5;
         cyc(25);
         chk(loss_of_reference, 2'h2);
         @(posedge core_clk) refFast <= 0;
         cyc(25);
      end
   endtask
   task t_holdover;
      begin
         wait_state(`DRHC_ST_LOCK);
         @(posedge core_clk) refOn <= 0;
         wait_state(`DRHC_ST_HOLD);
         h = numQ;
         cyc(30);
         chk({loss_of_reference, holdoverQ, stLockLostQ}, 4'hf);
         chk(numQ, h);
         @(posedge core_clk) {clrLockLost, refOn} <= 3'h4;
         @(posedge core_clk) clrLockLost <= 0;
         cyc(30);
         chk({stLockLostQ, stateQ}, {1'b0, `DRHC_ST_HOLD});
         @(posedge core_clk) refOn <= 3;
         wait_state(`DRHC_ST_ACQ);
         chk(selQ, 0);
      end
   endtask
   task t_manual;
      begin
         @(posedge core_clk) {swManEn, swManSel} <= 3'h5;
         cyc(3);
         chk(selQ, 1);
         @(posedge core_clk) {pinManEn, pinManSel, cascValid} <= 4'hd;
         cyc(3);
         chk(selQ, 2);
         @(posedge core_clk) {pinManEn, swManEn, refPrio} <= {2'h0, 9'h011};
         cyc(3);
         chk(selQ, 2);
         @(posedge core_clk) {refPrio, cascValid} <= {9'h1c8, 1'b0};
         cyc(3);
         chk(selQ, 0);
         @(posedge core_clk) dpllEn <= 0;
         cyc(2);
         chk({stateQ, apllFreeRunQ}, {`DRHC_ST_FREE, 1'b1});
      end
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1;
      t_free_dco;
      t_acquire;
      t_monitors;
      t_holdover;
      t_manual;
      complete_run;
   end
endmodule // drhc_dpll_ref_ctrl_tb
